// File: design/rfcfg_map.vh
`ifndef RFCFG_MAP_VH
`define RFCFG_MAP_VH
// ****************************************
// Register indices
// ****************************************
`define RFCFG_IDX_REG_BIAS 8'h0b
`define RFCFG_IDX_TX_CTRL 8'h0c
`define RFCFG_IDX_PIN_MISC 8'h0d
`define RFCFG_IDX_AUTO_CMD 8'h0f
// ****************************************
// Reset values
// ****************************************
`define RFCFG_RST_REG_BIAS 8'h1b
`define RFCFG_RST_TX_CTRL 8'h02
`define RFCFG_RST_PIN_MISC 8'h80
// ****************************************
// Writable bit masks, reserved bits read zero
// ****************************************
`define RFCFG_WMASK_REG_BIAS 8'hff
`define RFCFG_WMASK_TX_CTRL 8'hef
`define RFCFG_WMASK_PIN_MISC 8'hfc
// ****************************************
// Field positions
// ****************************************
`define RFCFG_BOOST_X4 7
`define RFCFG_BOOST_X2 6
`define RFCFG_AMPV_MSB 5
`define RFCFG_AMPV_LSB 3
`define RFCFG_GENV_MSB 2
`define RFCFG_GENV_LSB 0
`define RFCFG_LO_GAIN 7
`define RFCFG_LO_SRC 6
`define RFCFG_AMP_REG_EN 5
`define RFCFG_MAINPA_MSB 3
`define RFCFG_MAINPA_LSB 2
`define RFCFG_LPRF_MSB 1
`define RFCFG_LPRF_LSB 0
`define RFCFG_FAST_COMM 7
`define RFCFG_FAST_TEST 6
`define RFCFG_PD_SEL 5
`define RFCFG_PD_DESEL 4
`define RFCFG_NMOS_ONLY 3
`define RFCFG_SE_MIX 2
// ****************************************
// Direct command and drop codes
// ****************************************
`define RFCFG_CMD_AUTO_REG 8'ha2
`define RFCFG_DROP_250 3'h1
`define RFCFG_DROP_300 3'h3
`define RFCFG_DROP_350 3'h7
`endif

// File: design/rfcfg_regs.v
`timescale 1ns/10ps
`include "rfcfg_map.vh"
module rfcfg_regs (
    input wire i_sys_clk,
    input wire i_resetn,
    input wire [7:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output wire [31:0] o_avs_readdata,
    output wire o_avs_waitrequest,
    output wire [1:0] o_avs_response,
    input wire i_chip_select_n,
    input wire i_sdo_driven,
    input wire [2:0] i_measured_drop_code,
    input wire i_drop_settled,
    output reg [2:0] o_gen_supply_code,
    output reg [2:0] o_amp_supply_code,
    output reg o_auto_busy,
    output reg [2:0] o_amp_bias_mult,
    output reg o_lo_gain_6db,
    output reg o_lo_src_predriver,
    output reg o_amp_reg_en,
    output reg [1:0] o_predriver_bias,
    output reg [1:0] o_lowpower_rf_bias,
    output reg o_fast_comm_drivers,
    output reg o_fast_test_drivers,
    output reg o_sdo_pulldown,
    output reg o_nmos_only_drive,
    output reg o_mixer_single_ended
);
    // ****************************************
    // Registers
    // ****************************************
    reg [7:0] regulator_and_amp_bias;
    reg [7:0] rf_output_and_lo_control;
    reg [7:0] pin_driver_and_mixer_misc;
    reg auto_mode;
    reg [1:0] auto_state;
    reg [7:0] rd_word;
    reg rd_ack;
    reg [1:0] rd_resp;
    reg [2:0] next_amp_code;
    reg [2:0] next_gen_code;
    reg [2:0] drop_target_code;
    reg [7:0] next_rd_word;
    wire [7:0] word_idx;
    wire hit_bias;
    wire hit_tx;
    wire hit_misc;
    wire hit_cmd;
    wire hit_any;
    wire wr_lo;
    // ****************************************
    // Pad and field helper terms
    // ****************************************
    wire [1:0] main_amp_field;
    wire [1:0] lowpower_field;
    wire main_amp_on;
    wire pd_selected_term;
    wire pd_deselected_term;
    localparam RESP_OKAY = 2'b00;
    localparam RESP_SLVERR = 2'b10;
    localparam ST_IDLE = 2'd0;
    localparam ST_WAIT = 2'd1;
    localparam ST_DONE = 2'd2;
    // ****************************************
    // Bus decode
    // ****************************************
    // Index times four is the byte address; only the low lane carries data
    assign word_idx = {2'b00, i_avs_address[7:2]};
    assign hit_bias = (word_idx == `RFCFG_IDX_REG_BIAS);
    assign hit_tx = (word_idx == `RFCFG_IDX_TX_CTRL);
    assign hit_misc = (word_idx == `RFCFG_IDX_PIN_MISC);
    assign hit_cmd = (word_idx == `RFCFG_IDX_AUTO_CMD);
    assign hit_any = hit_bias | hit_tx | hit_misc | hit_cmd;
    assign wr_lo = i_avs_write & i_avs_byteenable[0];
    // Writes finish at once; reads wait one cycle for the registered data
    assign o_avs_waitrequest = i_avs_read & ~rd_ack;
    assign o_avs_readdata = {24'h000000, rd_word};
    assign o_avs_response = rd_resp;

    // ****************************************
    // Read path
    // ****************************************
    // Data are picked in the wait cycle so the bus sees a flop output
    always @* begin
        next_rd_word = 8'h00;
        if (hit_bias) begin
            next_rd_word = regulator_and_amp_bias;
        end else if (hit_tx) begin
            next_rd_word = rf_output_and_lo_control;
        end else if (hit_misc) begin
            next_rd_word = pin_driver_and_mixer_misc;
        end else if (hit_cmd) begin
            // Busy flag and the drop class that auto mode aims at
            next_rd_word = {1'b0, drop_target_code, 3'h0, o_auto_busy};
        end
    end

    // Ack alternates so a held read is answered once per two cycles
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_ack <= 1'b0;
        end else begin
            rd_ack <= i_avs_read & ~rd_ack;
        end
    end

    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_word <= 8'h00;
            rd_resp <= RESP_OKAY;
        end else if (i_avs_read & ~rd_ack) begin
            rd_word <= next_rd_word;
            rd_resp <= hit_any ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // ****************************************
    // Configuration storage
    // ****************************************
    // Reserved bits are masked so they always read zero
    // Boost and both supply codes, every bit writable
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            regulator_and_amp_bias <= `RFCFG_RST_REG_BIAS;
        end else if (wr_lo & hit_bias) begin
            regulator_and_amp_bias <=
                i_avs_writedata[7:0] & `RFCFG_WMASK_REG_BIAS;
        end
    end

    // Transmit enables, reserved bit 4 masked
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rf_output_and_lo_control <= `RFCFG_RST_TX_CTRL;
        end else if (wr_lo & hit_tx) begin
            rf_output_and_lo_control <=
                i_avs_writedata[7:0] & `RFCFG_WMASK_TX_CTRL;
        end
    end

    // Pin drivers and mixer, two low bits masked
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pin_driver_and_mixer_misc <= `RFCFG_RST_PIN_MISC;
        end else if (wr_lo & hit_misc) begin
            pin_driver_and_mixer_misc <=
                i_avs_writedata[7:0] & `RFCFG_WMASK_PIN_MISC;
        end
    end

    // ****************************************
    // Automatic supply setting
    // ****************************************
    // Drop target from the general code; unlisted codes fall to the 300 mV
    // class, the drop the regulators need for correct operation
    always @* begin
        case (regulator_and_amp_bias[`RFCFG_GENV_MSB:`RFCFG_GENV_LSB])
            `RFCFG_DROP_250: drop_target_code = `RFCFG_DROP_250;
            `RFCFG_DROP_350: drop_target_code = `RFCFG_DROP_350;
            default: drop_target_code = `RFCFG_DROP_300;
        endcase
    end

    always @* begin
        next_gen_code =
            regulator_and_amp_bias[`RFCFG_GENV_MSB:`RFCFG_GENV_LSB];
        next_amp_code =
            regulator_and_amp_bias[`RFCFG_AMPV_MSB:`RFCFG_AMPV_LSB];
        if (auto_mode) begin
            // Measured code is the supply code meeting the target drop
            next_gen_code = i_measured_drop_code;
            if (i_measured_drop_code < next_amp_code) begin
                next_amp_code = i_measured_drop_code;
            end
        end
    end

    // Command write of the trigger value starts one adjustment; the analog
    // side reports the settled code, a later manual write drops auto mode
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            auto_state <= ST_IDLE;
            auto_mode <= 1'b0;
            o_auto_busy <= 1'b0;
        end else begin
            case (auto_state)
                ST_IDLE: begin
                    if (wr_lo & hit_cmd &
                        (i_avs_writedata[7:0] == `RFCFG_CMD_AUTO_REG)) begin
                        auto_state <= ST_WAIT;
                        o_auto_busy <= 1'b1;
                    end else if (wr_lo & hit_bias) begin
                        auto_mode <= 1'b0;
                    end
                end
                ST_WAIT: begin
                    if (i_drop_settled) begin
                        auto_state <= ST_DONE;
                        auto_mode <= 1'b1;
                    end
                end
                default: begin
                    auto_state <= ST_IDLE;
                    o_auto_busy <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // Supply code outputs
    // ****************************************
    // Codes pass a flop so the regulators see one clean step
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_gen_supply_code <= 3'h3;
            o_amp_supply_code <= 3'h3;
        end else begin
            o_gen_supply_code <= next_gen_code;
            o_amp_supply_code <= next_amp_code;
        end
    end

    // ****************************************
    // Amplifier bias boost
    // ****************************************
    // One-hot multiplier: 1, 2 or 4; both bits set takes the larger
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_amp_bias_mult <= 3'h1;
        end else if (regulator_and_amp_bias[`RFCFG_BOOST_X4]) begin
            o_amp_bias_mult <= 3'h4;
        end else if (regulator_and_amp_bias[`RFCFG_BOOST_X2]) begin
            o_amp_bias_mult <= 3'h2;
        end else begin
            o_amp_bias_mult <= 3'h1;
        end
    end

    // ****************************************
    // Local oscillator path
    // ****************************************
    // Gain and source change only between transmissions in normal use
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_lo_gain_6db <= 1'b0;
            o_lo_src_predriver <= 1'b0;
        end else begin
            o_lo_gain_6db <=
                rf_output_and_lo_control[`RFCFG_LO_GAIN];
            o_lo_src_predriver <=
                rf_output_and_lo_control[`RFCFG_LO_SRC];
        end
    end

    // ****************************************
    // Amplifier enables
    // ****************************************
    // Regulator follows the main field so the pre-driver is never unfed
    assign main_amp_field = rf_output_and_lo_control[`RFCFG_MAINPA_MSB:
        `RFCFG_MAINPA_LSB];
    assign lowpower_field = rf_output_and_lo_control[`RFCFG_LPRF_MSB:
        `RFCFG_LPRF_LSB];
    assign main_amp_on = |main_amp_field;
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_amp_reg_en <= 1'b0;
            o_predriver_bias <= 2'b00;
            o_lowpower_rf_bias <= 2'b10;
        end else begin
            o_amp_reg_en <= rf_output_and_lo_control[`RFCFG_AMP_REG_EN] |
                main_amp_on;
            o_predriver_bias <= main_amp_field;
            o_lowpower_rf_bias <= lowpower_field;
        end
    end

    // ****************************************
    // Pin drivers
    // ****************************************
    // Strength and open drain only steer the pad cells from here
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_fast_comm_drivers <= 1'b1;
            o_fast_test_drivers <= 1'b0;
            o_nmos_only_drive <= 1'b0;
        end else begin
            o_fast_comm_drivers <=
                pin_driver_and_mixer_misc[`RFCFG_FAST_COMM];
            o_fast_test_drivers <=
                pin_driver_and_mixer_misc[`RFCFG_FAST_TEST];
            o_nmos_only_drive <=
                pin_driver_and_mixer_misc[`RFCFG_NMOS_ONLY];
        end
    end

    // ****************************************
    // Serial data out pull-down
    // ****************************************
    // Selected pull-down waits until the line is free and releases at the first edge that sees it driven
    assign pd_selected_term = pin_driver_and_mixer_misc[`RFCFG_PD_SEL] &
        ~i_chip_select_n & ~i_sdo_driven;
    assign pd_deselected_term = pin_driver_and_mixer_misc[`RFCFG_PD_DESEL] &
        i_chip_select_n;
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_sdo_pulldown <= 1'b0;
        end else begin
            o_sdo_pulldown <= pd_selected_term | pd_deselected_term;
        end
    end

    // ****************************************
    // Mixer input
    // ****************************************
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_mixer_single_ended <= 1'b0;
        end else begin
            o_mixer_single_ended <=
                pin_driver_and_mixer_misc[`RFCFG_SE_MIX];
        end
    end
endmodule

// File: tb/rfcfg_checker.sv
`timescale 1ns/10ps
module rfcfg_checker (
    input wire i_sys_clk,
    input wire i_resetn,
    input wire [7:0] i_avs_address,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    input wire [2:0] o_gen_supply_code,
    input wire [2:0] o_amp_supply_code,
    input wire o_auto_busy,
    input wire [2:0] o_amp_bias_mult,
    input wire o_lo_gain_6db,
    input wire o_amp_reg_en,
    input wire [1:0] o_predriver_bias,
    input wire [1:0] o_lowpower_rf_bias,
    input wire o_fast_comm_drivers,
    input wire o_nmos_only_drive
);
    // ******
    // Write decode, outputs follow one edge later
    // ******
    wire [7:0] wd = i_avs_writedata[7:0];
    wire wr = i_avs_write && i_avs_byteenable[0];
    wire wr_bias = wr && i_avs_address == 8'h2c;
    wire wr_tx = wr && i_avs_address == 8'h30;
    wire wr_misc = wr && i_avs_address == 8'h34;
    wire wr_cmd = wr && i_avs_address == 8'h3c && wd == 8'ha2;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    // Register stores at the write edge, the output flop one edge later
    a_boost_mult: assert property (wr_bias |=> ##1
        o_amp_bias_mult == ($past(wd[7], 2) ? 3'h4 :
        $past(wd[6], 2) ? 3'h2 : 3'h1)) else $error("mult");
    // Busy guard: a write during auto adjust may not leave auto mode
    a_manual_codes: assert property (wr_bias && !o_auto_busy
        |=> ##1 {o_amp_supply_code, o_gen_supply_code} == $past(wd[5:0], 2))
        else $error("codes");
    a_lo_gain: assert property (wr_tx |=> ##1
        o_lo_gain_6db == $past(wd[7], 2)) else $error("lo gain");
    a_amp_reg_on: assert property (wr_tx |=> ##1
        o_amp_reg_en == $past(wd[5] || wd[3:2] != 2'b00, 2))
        else $error("reg en");
    a_tx_fields: assert property (wr_tx |=> ##1
        {o_predriver_bias, o_lowpower_rf_bias} == $past(wd[3:0], 2))
        else $error("bias fields");
    a_fast_comm: assert property (wr_misc |=> ##1
        o_fast_comm_drivers == $past(wd[7], 2)) else $error("fast comm");
    a_nmos_drive: assert property (wr_misc |=> ##1
        o_nmos_only_drive == $past(wd[3], 2)) else $error("open drain");
    a_auto_start: assert property ($rose(o_auto_busy) |->
        $past(wr_cmd) || $past(wr_cmd, 2)) else $error("auto start");
    c_cmd: cover property (wr_cmd);
    c_done: cover property (o_auto_busy ##1 !o_auto_busy);
    c_misc: cover property (wr_misc);
endmodule
bind rfcfg_regs rfcfg_checker rfcfg_checker_i (.i_sys_clk, .i_resetn,
    .i_avs_address, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
    .o_gen_supply_code, .o_amp_supply_code, .o_auto_busy, .o_amp_bias_mult,
    .o_lo_gain_6db, .o_amp_reg_en, .o_predriver_bias, .o_lowpower_rf_bias,
    .o_fast_comm_drivers, .o_nmos_only_drive);

// File: tb/tb_rfcfg_regs.sv
`timescale 1ns/10ps
module tb_rfcfg_regs;
    logic i_sys_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [7:0] i_avs_address = 8'h00;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [3:0] i_avs_byteenable = 4'h1;
    logic i_chip_select_n = 1'b1;
    logic i_sdo_driven = 1'b0;
    logic [2:0] i_measured_drop_code = 3'h0;
    logic i_drop_settled = 1'b0;
    logic [31:0] o_avs_readdata;
    logic [1:0] o_avs_response, o_predriver_bias, o_lowpower_rf_bias;
    logic [2:0] o_gen_supply_code, o_amp_supply_code, o_amp_bias_mult;
    logic o_avs_waitrequest, o_auto_busy, o_lo_gain_6db, o_lo_src_predriver;
    logic o_amp_reg_en, o_fast_comm_drivers, o_fast_test_drivers;
    logic o_sdo_pulldown, o_nmos_only_drive, o_mixer_single_ended;
    logic [33:0] exp_q[$];
    logic [31:0] d;
    int mismatches = 0;
    int num_checks = 0;
    int seed = 10557;
    always #5 i_sys_clk = ~i_sys_clk;
    rfcfg_regs rfcfg_regs_i (.i_sys_clk, .i_resetn, .i_avs_address,
        .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
        .o_avs_readdata, .o_avs_waitrequest, .o_avs_response, .i_chip_select_n,
        .i_sdo_driven, .i_measured_drop_code, .i_drop_settled,
        .o_gen_supply_code, .o_amp_supply_code, .o_auto_busy, .o_amp_bias_mult,
        .o_lo_gain_6db, .o_lo_src_predriver, .o_amp_reg_en, .o_predriver_bias,
        .o_lowpower_rf_bias, .o_fast_comm_drivers, .o_fast_test_drivers,
        .o_sdo_pulldown, .o_nmos_only_drive, .o_mixer_single_ended);
    // ******
    // Report and compare
    // ******
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic tmo;
        mismatches++;
        $display("MISMATCH %0t wait timed out", $time);
        complete_run();
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t output %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_rd(input logic [33:0] e);
        num_checks++;
        if ({o_avs_response, o_avs_readdata} !== e) begin
            mismatches++;
            $display("MISMATCH %0t read %h expected %h", $time,
                o_avs_readdata, e[31:0]);
        end
    endtask
    // Read results are popped at the edge the master takes them
    always @(posedge i_sys_clk) begin
        if (i_resetn && i_avs_read && o_avs_waitrequest === 1'b0) begin
            if (exp_q.size() > 0) cmp_rd(exp_q.pop_front());
            else chk(16'h1, 16'h0);
        end
    end
    // ******
    // Bus master, request held until waitrequest is seen low
    // ******
    task automatic req(input logic rd, input logic [7:0] a,
            input logic [7:0] v, input logic [3:0] b);
        int n;
        logic busy;
        n = 0;
        i_avs_address <= a;
        i_avs_writedata <= {24'h0, v};
        i_avs_byteenable <= b;
        i_avs_read <= rd;
        i_avs_write <= !rd;
        // Waitrequest is looked at mid-cycle, where it has settled
        do begin
            @(negedge i_sys_clk);
            busy = o_avs_waitrequest !== 1'b0;
            @(posedge i_sys_clk);
            n++;
        end while (busy && n < 40);
        if (busy) tmo();
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
        @(posedge i_sys_clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] v,
            input logic [1:0] r);
        exp_q.push_back({r, 24'h0, v});
        req(1'b1, a, 8'h00, 4'h1);
    endtask
    // ******
    // Scenarios
    // ******
    initial begin
        repeat (3) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        @(posedge i_sys_clk);
        chk({o_amp_bias_mult, o_lowpower_rf_bias}, 16'h06);
        rd_chk(8'h2c, 8'h1b, 2'b00);
        rd_chk(8'h30, 8'h02, 2'b00);
        rd_chk(8'h34, 8'h80, 2'b00);
        rd_chk(8'h00, 8'h00, 2'b10);
        $display("test reset values done");
        for (int k = 0; k < 16; k++) begin
            d = $random(seed);
            d[12] = 1'b0;
            d[17:16] = 2'b00;
            i_chip_select_n <= d[24];
            i_sdo_driven <= d[25];
            req(1'b0, 8'h2c, d[7:0], 4'h1);
            req(1'b0, 8'h30, d[15:8], 4'h1);
            req(1'b0, 8'h34, d[23:16], 4'h1);
            repeat (2) @(posedge i_sys_clk);
            chk({o_amp_bias_mult, o_amp_supply_code, o_gen_supply_code},
                {d[7] ? 3'h4 : d[6] ? 3'h2 : 3'h1,
                d[5:0]});
            chk({o_lo_gain_6db, o_lo_src_predriver, o_amp_reg_en,
                o_predriver_bias, o_lowpower_rf_bias},
                {d[15:14], d[13] | (d[11:10] != 2'b00),
                d[11:8]});
            chk({o_fast_comm_drivers, o_fast_test_drivers,
                o_nmos_only_drive, o_mixer_single_ended},
                {d[23:22], d[19:18]});
            chk(o_sdo_pulldown, {15'h0000,
                d[21] & ~d[24] & ~d[25] | d[20] & d[24]});
            rd_chk(8'h30, d[15:8], 2'b00);
            rd_chk(8'h34, d[23:16], 2'b00);
        end
        req(1'b0, 8'h34, 8'h00, 4'he);
        rd_chk(8'h34, d[23:16], 2'b00);
        $display("test register fields done");
        req(1'b0, 8'h2c, 8'h2f, 4'h1);
        req(1'b0, 8'h3c, 8'h55, 4'h1);
        repeat (3) @(posedge i_sys_clk);
        chk(o_auto_busy, 16'h0);
        for (int k = 0; k < 2; k++) begin
            i_measured_drop_code <= k ? 3'h3 : 3'h6;
            req(1'b0, 8'h3c, 8'ha2, 4'h1);
            @(posedge i_sys_clk);
            chk(o_auto_busy, 16'h1);
            i_drop_settled <= 1'b1;
            // Busy is looked at mid-cycle, then the bench returns to an edge
            for (int w = 0; o_auto_busy !== 1'b0; w++) begin
                if (w > 30) tmo();
                @(negedge i_sys_clk);
            end
            @(posedge i_sys_clk);
            i_drop_settled <= 1'b0;
            repeat (2) @(posedge i_sys_clk);
            chk(o_gen_supply_code, k ? 16'h3 : 16'h6);
            chk(o_amp_supply_code, k ? 16'h3 : 16'h5);
        end
        rd_chk(8'h3c, 8'h70, 2'b00);
        $display("test auto regulator done");
        complete_run();
    end
endmodule
